// ### hw/swa_pkg.sv
// Package for the write select, lane mask and address input block
package swa_pkg;
    localparam int SWA_DATA_W = 8;
    localparam int SWA_NIB_W = 4;
    localparam int SWA_NIBS = 2;
    localparam int SWA_ADDR_W = 19;
    localparam int SWA_ADDR_W_X18 = 18;
    localparam int SWA_ADDR_W_X36 = 17;
    localparam int SWA_BURST = 4;
    localparam int SWA_BEAT_W = 2;
    localparam logic [1:0] SWA_BEAT_LAST = 2'h3;
    localparam logic [1:0] SWA_BEAT_FIRST = 2'h0;
    localparam logic [1:0] SWA_SYNC_RST = 2'h0;
    localparam logic [1:0] SWA_SYNC_SET = 2'h3;

    typedef enum logic [1:0]
    {
        SWA_W_IDLE = 2'h0,
        SWA_W_BEAT = 2'h1
    } swa_wstate_t;

    typedef struct packed
    {
        logic [SWA_ADDR_W-1:0] addr;
        logic [SWA_BEAT_W-1:0] beat;
        logic [SWA_DATA_W-1:0] data;
        logic [SWA_NIBS-1:0] lane_en;
    } swa_wr_t;

    typedef struct packed
    {
        logic [SWA_ADDR_W-1:0] addr;
        logic valid;
    } swa_rd_t;
endpackage

// ### hw/swa_input_ctrl.sv
// Write select, nibble mask and shared address input control
//
// Contract
// - Write select low on positive edge starts a write.
// - Write select high while idle: no write starts, data inputs ignored.
// - Mask zero gates bits 3:0, mask one gates bits 7:4.
// - Each mask taken on the same edge as its data word.
// - Nibble with mask high is discarded, not stored.
// - Lane masks sampled on the positive clock edge choose stored lanes.
// - Masked lanes keep their old array contents.
// - Address captured on positive edge when read or write requested.
// - One shared address bus carries read and write addresses.
// - Storage is four equal sub-arrays, one address picks four words.
// - Address is 19 bits in the eight-bit configuration.
// - Address ignored when that port is deselected.
// - Data sampled on the positive edge only during a valid write.
// - Read select low starts a four-transfer read.
`timescale 1ns/1ps
`default_nettype none
module swa_input_ctrl
    import swa_pkg::*;
(
    input wire logic clk_i,
    input wire logic clk_n_i,
    input wire logic reset_n_i,
    input wire logic write_port_select_n_i,
    input wire logic read_port_select_n_i,
    input wire logic [SWA_ADDR_W-1:0] addr_i,
    input wire logic [SWA_DATA_W-1:0] data_i,
    input wire logic [SWA_NIBS-1:0] nibble_lane_mask_n_i,
    output logic wr_valid_o,
    output swa_wr_t wr_o,
    output swa_rd_t rd_o,
    output logic wr_busy_o,
    output logic [SWA_BEAT_W-1:0] rd_beat_o,
    output logic rd_busy_o
);
    // ==========================================================
    // Reset release
    logic [1:0] rst_sync;
    logic rst_n;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rst_sync <= SWA_SYNC_RST;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // ==========================================================
    // Lane decode
    function automatic logic [SWA_NIBS-1:0] lane_en_f(input logic [SWA_NIBS-1:0] m_n);
        lane_en_f = ~m_n;
    endfunction

    // ==========================================================
    // Write burst control
    swa_wstate_t wstate;
    logic [SWA_BEAT_W-1:0] wbeat;
    logic [SWA_ADDR_W-1:0] waddr;
    logic wr_start;
    logic wr_active;

    assign wr_start = !write_port_select_n_i && (wstate == SWA_W_IDLE);
    assign wr_active = (wstate == SWA_W_BEAT);

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wstate <= SWA_W_IDLE;
            waddr <= '0;
        end
        else
        begin
            case (wstate)
                SWA_W_IDLE:
                begin
                    if (wr_start)
                    begin
                        wstate <= SWA_W_BEAT;
                        waddr <= addr_i;
                    end
                end
                SWA_W_BEAT:
                begin
                    if (wbeat == SWA_BEAT_LAST)
                        wstate <= SWA_W_IDLE;
                end
                default:
                    wstate <= SWA_W_IDLE;
            endcase
        end
    end

    // Beat counter, one beat per positive clock edge
    // Complementary clock unused, single clock domain
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            wbeat <= SWA_BEAT_FIRST;
        else if (wr_active)
            wbeat <= wbeat + 2'h1;
        else
            wbeat <= SWA_BEAT_FIRST;
    end

    // Data and masks on the same edge, only while writing
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_valid_o <= 1'b0;
            wr_o <= '0;
        end
        else
        begin
            wr_valid_o <= wr_active;
            if (wr_active)
            begin
                wr_o.addr <= waddr;
                wr_o.beat <= wbeat;
                wr_o.data <= data_i;
                wr_o.lane_en <= lane_en_f(nibble_lane_mask_n_i);
            end
        end
    end

    // ==========================================================
    // Read port select and address
    logic rd_active;
    logic [SWA_BEAT_W-1:0] rbeat;

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_o <= '0;
            rd_active <= 1'b0;
            rbeat <= SWA_BEAT_FIRST;
        end
        else
        begin
            rd_o.valid <= 1'b0;
            if (!rd_active && !read_port_select_n_i)
            begin
                rd_o.valid <= 1'b1;
                rd_o.addr <= addr_i;
                rd_active <= 1'b1;
                rbeat <= SWA_BEAT_FIRST;
            end
            else if (rd_active)
            begin
                rbeat <= rbeat + 2'h1;
                if (rbeat == SWA_BEAT_LAST)
                    rd_active <= 1'b0;
            end
        end
    end

    assign wr_busy_o = wr_active;
    assign rd_busy_o = rd_active;
    assign rd_beat_o = rbeat;

    // ==========================================================
    // Checks
    property p_wr_start;
        @(posedge clk_i) disable iff (!rst_n)
        wr_start |=> wr_active;
    endproperty
    a_wr_start: assert property (p_wr_start) else $error("write not started");

    property p_no_write_idle;
        @(posedge clk_i) disable iff (!rst_n)
        !wr_active |=> !wr_valid_o;
    endproperty
    a_no_write_idle: assert property (p_no_write_idle) else $error("data taken while idle");

    property p_lane;
        @(posedge clk_i) disable iff (!rst_n)
        wr_active |=> wr_o.lane_en == ~$past(nibble_lane_mask_n_i);
    endproperty
    a_lane: assert property (p_lane) else $error("lane enable mismatch");

    property p_same_edge;
        @(posedge clk_i) disable iff (!rst_n)
        wr_active |=> wr_o.data == $past(data_i);
    endproperty
    a_same_edge: assert property (p_same_edge) else $error("data not with mask");

    property p_burst4;
        @(posedge clk_i) disable iff (!rst_n)
        wr_start |=> wr_active [*4] ##1 !wr_active;
    endproperty
    a_burst4: assert property (p_burst4) else $error("write burst not four");

    property p_waddr;
        @(posedge clk_i) disable iff (!rst_n)
        wr_start |=> ##1 wr_o.addr == $past(addr_i, 2);
    endproperty
    a_waddr: assert property (p_waddr) else $error("write address wrong");

    property p_rd_addr;
        @(posedge clk_i) disable iff (!rst_n)
        rd_o.valid |-> rd_o.addr == $past(addr_i);
    endproperty
    a_rd_addr: assert property (p_rd_addr) else $error("read address wrong");

    property p_rd_burst;
        @(posedge clk_i) disable iff (!rst_n)
        rd_o.valid |-> rd_active [*4] ##1 !rd_active;
    endproperty
    a_rd_burst: assert property (p_rd_burst) else $error("read burst not four");

    property p_desel_idle;
        @(posedge clk_i) disable iff (!rst_n)
        (wstate == SWA_W_IDLE) && write_port_select_n_i |=> !wr_active;
    endproperty
    a_desel_idle: assert property (p_desel_idle) else $error("write while deselected");

    property p_data_hold;
        @(posedge clk_i) disable iff (!rst_n)
        !wr_active |=> $stable(wr_o.data);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data taken outside burst");

    property p_mask_drop;
        @(posedge clk_i) disable iff (!rst_n)
        wr_active |=> (wr_o.lane_en & $past(nibble_lane_mask_n_i)) == 2'h0;
    endproperty
    a_mask_drop: assert property (p_mask_drop) else $error("masked nibble enabled");

    property p_mask_keep;
        @(posedge clk_i) disable iff (!rst_n)
        wr_active |=> (wr_o.lane_en | $past(nibble_lane_mask_n_i)) == 2'h3;
    endproperty
    a_mask_keep: assert property (p_mask_keep) else $error("unmasked nibble dropped");

    property p_first_beat;
        @(posedge clk_i) disable iff (!rst_n)
        wr_start |=> ##1 wr_valid_o && (wr_o.beat == SWA_BEAT_FIRST);
    endproperty
    a_first_beat: assert property (p_first_beat) else $error("first beat wrong");

    property p_beat_step;
        @(posedge clk_i) disable iff (!rst_n)
        wr_valid_o && (wr_o.beat != SWA_BEAT_LAST) |=>
            wr_valid_o && (wr_o.beat == $past(wr_o.beat) + 2'h1);
    endproperty
    a_beat_step: assert property (p_beat_step) else $error("beat order wrong");

    property p_burst_end;
        @(posedge clk_i) disable iff (!rst_n)
        wr_valid_o && (wr_o.beat == SWA_BEAT_LAST) |=> !wr_valid_o;
    endproperty
    a_burst_end: assert property (p_burst_end) else $error("burst longer than four");

    property p_wr_valid_len;
        @(posedge clk_i) disable iff (!rst_n)
        wr_start |=> ##1 wr_valid_o [*4] ##1 !wr_valid_o;
    endproperty
    a_wr_valid_len: assert property (p_wr_valid_len) else $error("beat count wrong");

    property p_addr_stable;
        @(posedge clk_i) disable iff (!rst_n)
        wr_valid_o && (wr_o.beat != SWA_BEAT_FIRST) |-> $stable(wr_o.addr);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved in burst");

    property p_waddr_ignored;
        @(posedge clk_i) disable iff (!rst_n)
        !wr_start |=> $stable(waddr);
    endproperty
    a_waddr_ignored: assert property (p_waddr_ignored) else $error("write address taken");

    property p_rd_refused;
        @(posedge clk_i) disable iff (!rst_n)
        rd_active |=> !rd_o.valid;
    endproperty
    a_rd_refused: assert property (p_rd_refused) else $error("read restarted in burst");

    property p_rd_idle;
        @(posedge clk_i) disable iff (!rst_n)
        read_port_select_n_i && !rd_active |=> !rd_o.valid;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read while deselected");

    property p_rd_addr_hold;
        @(posedge clk_i) disable iff (!rst_n)
        rd_active || read_port_select_n_i |=> $stable(rd_o.addr);
    endproperty
    a_rd_addr_hold: assert property (p_rd_addr_hold) else $error("read address taken");

    property p_rd_first;
        @(posedge clk_i) disable iff (!rst_n)
        rd_o.valid |-> rbeat == SWA_BEAT_FIRST;
    endproperty
    a_rd_first: assert property (p_rd_first) else $error("read beat not first");

    property p_rd_done;
        @(posedge clk_i) disable iff (!rst_n)
        rd_active && (rbeat == SWA_BEAT_LAST) |=> !rd_active;
    endproperty
    a_rd_done: assert property (p_rd_done) else $error("read burst not ended");

    c_write: cover property (@(posedge clk_i) disable iff (!rst_n) wr_start);
    c_read: cover property (@(posedge clk_i) disable iff (!rst_n) rd_o.valid);
    c_both: cover property (@(posedge clk_i) disable iff (!rst_n) wr_active && rd_active);
    c_masked: cover property (@(posedge clk_i) disable iff (!rst_n)
        wr_valid_o && wr_o.lane_en != 2'h3);
    c_back_to_back: cover property (@(posedge clk_i) disable iff (!rst_n)
        (wr_valid_o && (wr_o.beat == SWA_BEAT_LAST)) ##1 wr_active);
endmodule // swa_input_ctrl
`default_nettype wire

// ### verification/swa_ctrl_model.sv
// Memory controller model driving the input side
`timescale 1ns/1ps
`default_nettype none
module swa_ctrl_model
    import swa_pkg::*;
(
    input wire logic clk_i,
    output logic write_port_select_n_o,
    output logic read_port_select_n_o,
    output logic [SWA_ADDR_W-1:0] addr_o,
    output logic [SWA_DATA_W-1:0] data_o,
    output logic [SWA_NIBS-1:0] nibble_lane_mask_n_o
);
    initial
    begin
        write_port_select_n_o = 1'b1;
        read_port_select_n_o = 1'b1;
        addr_o = '0;
        data_o = '0;
        nibble_lane_mask_n_o = 2'h3;
    end

    // ==========================================
    // Write burst: select, then four beats
    task automatic write_burst(input logic [18:0] a, input logic [31:0] d, input logic [7:0] m);
        @(negedge clk_i);
        write_port_select_n_o = 1'b0;
        addr_o = a;
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clk_i);
            write_port_select_n_o = 1'b1;
            addr_o = ~a;
            data_o = d[8*i +: 8];
            nibble_lane_mask_n_o = m[2*i +: 2];
        end
        @(negedge clk_i);
        data_o = ~data_o;
        nibble_lane_mask_n_o = ~nibble_lane_mask_n_o;
    endtask

    // ==========================================
    // Read request on the shared address bus
    task automatic read_req(input logic [18:0] a);
        @(negedge clk_i);
        read_port_select_n_o = 1'b0;
        addr_o = a;
        @(negedge clk_i);
        read_port_select_n_o = 1'b1;
        addr_o = ~a;
    endtask
endmodule // swa_ctrl_model
`default_nettype wire

// ### verification/sram_write_select_addr_input_tb_top.sv
// Testbench for the input control block
`timescale 1ns/1ps
`default_nettype none
module sram_write_select_addr_input_tb_top
    import swa_pkg::*;
;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic wps_n, rps_n, wr_valid;
    logic wr_busy, rd_busy;
    logic [SWA_BEAT_W-1:0] rd_beat;
    logic [SWA_ADDR_W-1:0] addr;
    logic [SWA_DATA_W-1:0] data;
    logic [SWA_NIBS-1:0] mask_n;
    swa_wr_t wr;
    swa_rd_t rd;
    int miscompares = 0;
    int n_checks = 0;

    always #25 clk = ~clk;

    swa_ctrl_model i_ctrl (.clk_i(clk), .write_port_select_n_o(wps_n),
        .read_port_select_n_o(rps_n), .addr_o(addr), .data_o(data),
        .nibble_lane_mask_n_o(mask_n));

    swa_input_ctrl i_dut (.clk_i(clk), .clk_n_i(~clk), .reset_n_i(reset_n),
        .write_port_select_n_i(wps_n), .read_port_select_n_i(rps_n), .addr_i(addr),
        .data_i(data), .nibble_lane_mask_n_i(mask_n), .wr_valid_o(wr_valid), .wr_o(wr),
        .rd_o(rd), .wr_busy_o(wr_busy), .rd_beat_o(rd_beat), .rd_busy_o(rd_busy));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================
    // Masked write burst, beats checked in turn
    task automatic test_write(input logic [18:0] a, input logic [31:0] d, input logic [7:0] m);
        logic [1:0] en;
        logic [7:0] lm;
        fork
            i_ctrl.write_burst(a, d, m);
            repeat (3) @(negedge clk);
        join_any
        for (int i = 0; i < 4; i++)
        begin
            en = ~m[2*i +: 2];
            lm = {{4{en[1]}}, {4{en[0]}}};
            check(wr_valid, 1'b1);
            check(wr_busy, i < 3);
            check(wr.addr, a);
            check(wr.beat, i);
            check(wr.lane_en, en);
            check(wr.data & lm, d[8*i +: 8] & lm);
            @(negedge clk);
        end
        wait fork;
        check(wr_valid, 1'b0);
        check(wr_busy, 1'h0);
    endtask

    // ==========================================
    // Deselected ports: no write or read valid for six cycles
    task automatic test_idle();
        for (int i = 0; i < 6; i++)
        begin
            @(negedge clk);
            check(wr_valid, 1'b0);
            check(rd.valid, 1'b0);
        end
    endtask

    // ==========================================
    // Read start on shared bus, no write taken
    task automatic test_read(input logic [18:0] a);
        fork
            i_ctrl.read_req(a);
        join_none
        repeat (2) @(negedge clk);
        check(rd.valid, 1'b1);
        check(rd.addr, a);
        check(wr_valid, 1'b0);
        check(rd_busy, 1'h1);
        check(rd_beat, 2'h0);
        @(negedge clk);
        check(rd.valid, 1'b0);
        check(rd_beat, 2'h1);
        repeat (4) @(negedge clk);
        check(rd_busy, 1'h0);
    endtask

    initial
    begin
        repeat (5) @(negedge clk);
        check(wr_valid, 1'h0);
        check(wr_busy, 1'h0);
        check(rd.valid, 1'h0);
        check(rd_busy, 1'h0);
        reset_n = 1'b1;
        repeat (3) @(negedge clk);
        test_write(19'h5a5a5, 32'ha5c33c5a, 8'b10_01_00_11);
        test_idle();
        test_read(19'h12345);
        test_write(19'h7ffff, 32'h0ff0f00f, 8'b00_11_10_01);
        test_idle();
        finish_test();
    end

    initial
    begin
        #20000;
        miscompares++;
        finish_test();
    end
endmodule // sram_write_select_addr_input_tb_top
`default_nettype wire
